// *** include/sfuri_pkg.sv ***
// Constants and carrier types for the serial flash unlock/reset/ID block
package sfuri_pkg;

   // Command opcodes
   localparam logic [7:0] GLOBAL_UNLOCK_OP = 8'h98;
   localparam logic [7:0] RESET_ARM_OP = 8'h66;
   localparam logic [7:0] RESET_EXEC_OP = 8'h99;
   localparam logic [7:0] NO_OPERATION_OP = 8'h00;
   localparam logic [7:0] READ_ID_OP = 8'h4B;
   localparam logic [7:0] READ_TABLE_OP = 8'h5A;

   // Frame layout in bits
   localparam logic [7:0] CMD_BITS = 8'h08;
   localparam logic [7:0] ADDR3_END = 8'h20;
   localparam logic [7:0] ADDR4_END = 8'h28;
   localparam logic [7:0] DUMMY_BITS = 8'h08;
   localparam logic [7:0] CNT_SAT = 8'hFF;
   localparam logic [7:0] STEP_SINGLE = 8'h01;
   localparam logic [7:0] STEP_QUAD = 8'h04;
   localparam logic [6:0] TOP_BIT = 7'h7F;

   // Output drive patterns, enable active low
   localparam logic [3:0] OE_NONE = 4'hF;
   localparam logic [3:0] OE_SINGLE = 4'hD;
   localparam logic [3:0] OE_QUAD = 4'h0;

   // Timing
   localparam int REF_CLK_MHZ = 200;
   localparam int RESET_LOW_MIN_NS = 1000;
   localparam int RESET_RELEASE_TO_SELECT_NS = 1000;
   localparam int RESET_LOW_CYCLES =
      (RESET_LOW_MIN_NS * REF_CLK_MHZ + 999) / 1000;
   localparam int RESET_CNT_W = $clog2(RESET_LOW_CYCLES + 1);
   localparam logic [RESET_CNT_W-1:0] RESET_LOW_LAST =
      RESET_CNT_W'(RESET_LOW_CYCLES - 1);
   localparam logic [RESET_CNT_W-1:0] RESET_LOW_FULL =
      RESET_CNT_W'(RESET_LOW_CYCLES);

   // Reset-signaling pulse tracker
   typedef enum logic [1:0] {
      SIG_IDLE = 2'b00,
      SIG_LOW1 = 2'b01,
      SIG_HIGH1 = 2'b10,
      SIG_LOW2 = 2'b11
   } sfuri_sig_t;

   // Link-clock state that lives across frames
   typedef struct packed {
      logic qpi_s1;
      logic qpi_s2;
      logic a4_s1;
      logic a4_s2;
      logic [7:0] cnt;
      logic [31:0] sh;
      logic [7:0] opcode;
      logic [3:0] addr_lo;
      logic [6:0] d;
      logic tog;
   } sfuri_link_t;

   // Link-clock state cleared by chip select high
   typedef struct packed {
      logic infrm;
      logic [3:0] dout;
      logic [3:0] oe_n;
   } sfuri_frame_t;

endpackage

// *** core/sfuri_core.sv ***
// Serial flash unlock, software/pin/protocol reset and ID/table read logic
`timescale 1ns/100ps

module sfuri_core #(
   parameter int NUM_BLOCKS = 16,
   parameter logic [7:0] WRITE_ENABLE_OP = 8'h06,
   // Arbitrary identifier value
   parameter logic [127:0] UNIQUE_ID =
      128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210,
   // Arbitrary table contents, byte 0 in the top bits
   parameter logic [127:0] PARAM_TABLE =
      128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Serial link
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic [3:0] io_i,
   output logic [3:0] io_o,
   output logic [3:0] io_oe_n_o,
   input wire logic reset_n_i,
   // Configuration
   input wire logic four_line_command_mode_i,
   input wire logic addr4_mode_i,
   input wire logic protection_scheme_select_i,
   input wire logic operation_in_progress_flag_i,
   // Lock query
   input wire logic [$clog2(NUM_BLOCKS)-1:0] lock_index_i,
   // Status
   output logic write_enable_latch_o,
   output logic lock_status_o,
   output logic block_protected_o,
   output logic device_reset_o,
   output logic operation_abort_o
);

   // Reference-clock state
   typedef struct packed {
      logic cs_s1;
      logic cs_s2;
      logic cs_s3;
      logic si_s1;
      logic si_s2;
      logic si_hold;
      logic tog_s1;
      logic tog_s2;
      logic tog_seen;
      logic rp_s1;
      logic rp_s2;
      logic [sfuri_pkg::RESET_CNT_W-1:0] rlow;
      logic armed;
      logic write_enable_latch;
      logic [NUM_BLOCKS-1:0] locks;
      sfuri_pkg::sfuri_sig_t sig;
      logic lock_st;
      logic prot;
      logic rst_pulse;
      logic abort;
   } sfuri_ref_t;

   sfuri_ref_t r;
   sfuri_ref_t next_r;
   sfuri_pkg::sfuri_link_t l;
   sfuri_pkg::sfuri_link_t next_l;
   sfuri_pkg::sfuri_frame_t f;
   sfuri_pkg::sfuri_frame_t next_f;

   logic link_arst;
   logic frame_arst;
   logic [7:0] base;
   logic [7:0] stepw;
   logic [8:0] sum;
   logic [7:0] new_cnt;
   logic [31:0] sh_n;
   logic [7:0] hdr_end;
   logic [7:0] start;
   logic is_rd;
   logic [6:0] d_n;
   logic [6:0] idx;
   logic [127:0] rot;
   logic [127:0] src;
   logic rise;
   logic clocked;
   logic hw_hit;
   logic rst_evt;
   logic cmd_ok;

   // Link resets: pin reset holds the link, select high ends a frame
   assign link_arst = rst_i | ~reset_n_i;
   assign frame_arst = link_arst | cs_n_i;

   // Link-clock next state: shift in, track phase, drive read data
   always_comb begin
      next_l = l;
      next_f = f;
      next_l.qpi_s1 = four_line_command_mode_i;
      next_l.qpi_s2 = l.qpi_s1;
      next_l.a4_s1 = addr4_mode_i;
      next_l.a4_s2 = l.a4_s1;
      base = f.infrm ? l.cnt : 8'h00;
      stepw = l.qpi_s2 ? sfuri_pkg::STEP_QUAD : sfuri_pkg::STEP_SINGLE;
      sum = {1'b0, base} + {1'b0, stepw};
      new_cnt = sum[8] ? sfuri_pkg::CNT_SAT : sum[7:0];
      // upper lines ignored in single mode
      sh_n = l.qpi_s2 ? {l.sh[27:0], io_i} : {l.sh[30:0], io_i[0]};
      hdr_end = l.a4_s2 ? sfuri_pkg::ADDR4_END : sfuri_pkg::ADDR3_END;
      start = hdr_end + sfuri_pkg::DUMMY_BITS;
      next_l.cnt = new_cnt;
      next_l.sh = sh_n;
      next_f.infrm = 1'b1;
      // First edge of a frame flips the crossing toggle
      if (!f.infrm) begin
         next_l.tog = ~l.tog;
      end
      if (new_cnt == sfuri_pkg::CMD_BITS) begin
         next_l.opcode = sh_n[7:0];
      end
      if (new_cnt == hdr_end) begin
         next_l.addr_lo = sh_n[3:0];
      end
      // ID or table data after address and dummy
      is_rd = (l.opcode == sfuri_pkg::READ_ID_OP) ||
              (l.opcode == sfuri_pkg::READ_TABLE_OP);
      rot = (PARAM_TABLE << {l.addr_lo, 3'b000}) |
            (PARAM_TABLE >> (8'h80 - {1'b0, l.addr_lo, 3'b000}));
      src = (l.opcode == sfuri_pkg::READ_ID_OP) ? UNIQUE_ID : rot;
      if (base >= start) begin
         d_n = l.d + stepw[6:0];
      end else begin
         d_n = 7'h00;
      end
      next_l.d = d_n;
      idx = sfuri_pkg::TOP_BIT - d_n;
      // drive only after clocked header, never before
      next_f.dout = 4'h0;
      next_f.oe_n = sfuri_pkg::OE_NONE;
      // table streams like a fast read
      if (is_rd && (new_cnt >= start)) begin
         if (l.qpi_s2) begin
            next_f.dout = src[idx -: 4];
            next_f.oe_n = sfuri_pkg::OE_QUAD;
         end else begin
            next_f.dout = {2'b00, src[idx], 1'b0};
            next_f.oe_n = sfuri_pkg::OE_SINGLE;
         end
      end
   end

   // Link state kept across frames
   always_ff @(posedge sclk_i or posedge link_arst) begin
      if (link_arst) begin
         l <= '0;
      end else begin
         l <= next_l;
      end
   end

   // pin reset floats the outputs asynchronously
   // select high ends output at any bit
   always_ff @(posedge sclk_i or posedge frame_arst) begin
      if (frame_arst) begin
         f <= '{infrm: 1'b0, dout: 4'h0, oe_n: sfuri_pkg::OE_NONE};
      end else begin
         f <= next_f;
      end
   end

   // Reference-clock next state: commands, resets, locks
   always_comb begin
      next_r = r;
      next_r.cs_s1 = cs_n_i;
      next_r.cs_s2 = r.cs_s1;
      next_r.cs_s3 = r.cs_s2;
      next_r.si_s1 = io_i[0];
      next_r.si_s2 = r.si_s1;
      next_r.tog_s1 = l.tog;
      next_r.tog_s2 = r.tog_s1;
      next_r.rp_s1 = reset_n_i;
      next_r.rp_s2 = r.rp_s1;
      next_r.rst_pulse = 1'b0;
      next_r.abort = 1'b0;
      rst_evt = 1'b0;
      rise = r.cs_s2 & ~r.cs_s3;
      clocked = r.tog_s2 != r.tog_seen;
      cmd_ok = l.cnt == sfuri_pkg::CMD_BITS;
      // hold data-in as last seen while selected
      if (!r.cs_s2) begin
         next_r.si_hold = r.si_s2;
      end
      // time the reset pin low phase
      if (r.rp_s2) begin
         next_r.rlow = '0;
      end else if (r.rlow != sfuri_pkg::RESET_LOW_FULL) begin
         next_r.rlow = r.rlow + 1'b1;
      end
      hw_hit = !r.rp_s2 && (r.rlow == sfuri_pkg::RESET_LOW_LAST);
      // Pin reset clears the link toggle, follow it to avoid a stale edge
      if (!r.rp_s2) begin
         next_r.tog_seen = r.tog_s2;
      end
      if (rise && r.rp_s2) begin
         next_r.tog_seen = r.tog_s2;
         if (!clocked) begin
            case (r.sig)
               sfuri_pkg::SIG_IDLE: begin
                  next_r.sig = r.si_hold ? sfuri_pkg::SIG_IDLE
                                         : sfuri_pkg::SIG_LOW1;
               end
               sfuri_pkg::SIG_LOW1: begin
                  next_r.sig = r.si_hold ? sfuri_pkg::SIG_HIGH1
                                         : sfuri_pkg::SIG_LOW1;
               end
               sfuri_pkg::SIG_HIGH1: begin
                  next_r.sig = r.si_hold ? sfuri_pkg::SIG_IDLE
                                         : sfuri_pkg::SIG_LOW2;
               end
               sfuri_pkg::SIG_LOW2: begin
                  if (r.si_hold) begin
                     rst_evt = 1'b1;
                  end else begin
                     next_r.sig = sfuri_pkg::SIG_LOW1;
                  end
               end
               default: begin
                  next_r.sig = sfuri_pkg::SIG_IDLE;
               end
            endcase
         end else begin
            next_r.sig = sfuri_pkg::SIG_IDLE;
            if (l.cnt >= sfuri_pkg::CMD_BITS) begin
               next_r.armed = 1'b0;
            end
            if (cmd_ok && (l.opcode == WRITE_ENABLE_OP)) begin
               next_r.write_enable_latch = 1'b1;
            end
            // only with select high right after the eighth bit
            if (cmd_ok && (l.opcode == sfuri_pkg::GLOBAL_UNLOCK_OP) &&
                r.write_enable_latch) begin
               next_r.locks = '0;
               next_r.write_enable_latch = 1'b0;
            end
            if (cmd_ok && (l.opcode == sfuri_pkg::RESET_ARM_OP)) begin
               next_r.armed = 1'b1;
            end
            if (cmd_ok && (l.opcode == sfuri_pkg::RESET_EXEC_OP) &&
                r.armed) begin
               rst_evt = 1'b1;
            end
         end
      end
      // latch, lock bits back at defaults
      // every lock bit set to one
      if (rst_evt || hw_hit) begin
         next_r.write_enable_latch = 1'b0;
         next_r.armed = 1'b0;
         next_r.locks = '1;
         next_r.sig = sfuri_pkg::SIG_IDLE;
         next_r.rst_pulse = 1'b1;
         next_r.abort = operation_in_progress_flag_i;
      end
      // status follows the lock bit itself
      next_r.lock_st = r.locks[lock_index_i];
      // locks apply only under the block scheme
      next_r.prot = protection_scheme_select_i & r.locks[lock_index_i];
   end

   // Reference-clock registers
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1,
                rp_s1: 1'b1, rp_s2: 1'b1, locks: '1, lock_st: 1'b1,
                sig: sfuri_pkg::SIG_IDLE, default: '0};
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from flip-flops
   assign io_o = f.dout;
   assign io_oe_n_o = f.oe_n;
   assign write_enable_latch_o = r.write_enable_latch;
   assign lock_status_o = r.lock_st;
   assign block_protected_o = r.prot;
   assign device_reset_o = r.rst_pulse;
   assign operation_abort_o = r.abort;

endmodule

// *** tb/sfuri_core_sva.sv ***
// Concurrent checks on the unlock, reset and identifier block ports
`timescale 1ns/100ps
module sfuri_core_sva (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Link
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic reset_n_i,
   input wire logic [3:0] io_oe_n_o,
   // Configuration
   input wire logic protection_scheme_select_i,
   input wire logic operation_in_progress_flag_i,
   // Status
   input wire logic write_enable_latch_o,
   input wire logic lock_status_o,
   input wire logic block_protected_o,
   input wire logic device_reset_o,
   input wire logic operation_abort_o
);
   logic seen_clk;
   logic [7:0] low_cnt;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // Clock seen in frame, pin low time
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         seen_clk <= 1'h0;
         low_cnt <= 8'h00;
      end else begin
         seen_clk <= !cs_n_i && (seen_clk || sclk_i);
         low_cnt <= reset_n_i ? 8'h00 :
            (low_cnt == 8'hFF ? low_cnt : low_cnt + 8'h01);
      end
   end
   property p_pin_float;
      !reset_n_i |-> io_oe_n_o == 4'hF;
   endproperty
   a_pin_float: assert property (p_pin_float) else $error("pin float");
   property p_cs_float;
      cs_n_i |-> io_oe_n_o == 4'hF;
   endproperty
   a_cs_float: assert property (p_cs_float) else $error("cs float");
   property p_no_early;
      !cs_n_i && !seen_clk && !sclk_i |-> io_oe_n_o == 4'hF;
   endproperty
   a_no_early: assert property (p_no_early) else $error("early");
   property p_rst_dflt;
      $fell(rst_i) |-> lock_status_o && !write_enable_latch_o;
   endproperty
   a_rst_dflt: assert property (p_rst_dflt) else $error("defaults");
   property p_abort;
      device_reset_o || operation_abort_o |-> device_reset_o &&
         operation_abort_o == $past(operation_in_progress_flag_i);
   endproperty
   a_abort: assert property (p_abort) else $error("abort");
   property p_clears;
      device_reset_o |-> ##[0:2] (!write_enable_latch_o && lock_status_o);
   endproperty
   a_clears: assert property (p_clears) else $error("clears");
   property p_pin_fire;
      low_cnt == 8'h00 && !reset_n_i |-> ##[1:210]
         (device_reset_o || reset_n_i);
   endproperty
   a_pin_fire: assert property (p_pin_fire) else $error("pin late");
   property p_pin_min;
      device_reset_o && !reset_n_i |-> low_cnt >= 8'hC6;
   endproperty
   a_pin_min: assert property (p_pin_min) else $error("pin early");
   property p_prot;
      !$past(rst_i) |-> block_protected_o ==
         ($past(protection_scheme_select_i) && lock_status_o);
   endproperty
   a_prot: assert property (p_prot) else $error("protect");
endmodule

bind sfuri_core sfuri_core_sva chk_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
   .sclk_i(sclk_i), .cs_n_i(cs_n_i), .reset_n_i(reset_n_i),
   .io_oe_n_o(io_oe_n_o),
   .protection_scheme_select_i(protection_scheme_select_i),
   .operation_in_progress_flag_i(operation_in_progress_flag_i),
   .write_enable_latch_o(write_enable_latch_o),
   .lock_status_o(lock_status_o), .block_protected_o(block_protected_o),
   .device_reset_o(device_reset_o), .operation_abort_o(operation_abort_o));

// *** tb/sfuri_host.sv ***
// Host flash controller model driving the serial link
`timescale 1ns/100ps
module sfuri_host (
   // Link toward the device
   output logic sclk_o,
   output logic cs_n_o,
   output logic [3:0] io_o,
   input wire logic [3:0] io_i
);
   // Idle link, clock parked low
   initial begin
      sclk_o = 1'h0;
      cs_n_o = 1'h1;
      io_o = 4'h0;
   end
   // One clocked frame, quad moves a nibble per clock
   task automatic frame(input logic [63:0] tx, input int nb, input logic q,
      input int rd, output logic [127:0] rx);
      rx = 128'h0;
      cs_n_o = 1'h0;
      for (int i = 0; i < nb + rd; i += (q ? 4 : 1)) begin
         // upper lines carry noise in single mode
         io_o = q ? ((i < nb) ? tx[63 - i -: 4] : 4'h0) :
            {3'($urandom), (i < nb) ? tx[63 - i] : 1'h0};
         if (i >= nb)
            rx = q ? {rx[123:0], io_i} : {rx[126:0], io_i[1]};
         #16 sclk_o = 1'h1;
         #16 sclk_o = 1'h0;
      end
      cs_n_o = 1'h1;
      io_o = ~io_o;
      #40;
   endtask
   // select pulse with data, no clock
   task automatic pulse(input logic v);
      cs_n_o = 1'h0;
      io_o[0] = v;
      #40 cs_n_o = 1'h1;
      #20 io_o[0] = ~v;
      #20;
   endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the unlock, reset and identifier block
`timescale 1ns/100ps
module tb;
   localparam logic [127:0] ID_VAL =
      128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
   localparam logic [127:0] TBL_VAL =
      128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF;
   localparam logic [7:0] WRITE_ENABLE_CMD_OP = 8'h06;
   logic ref_clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic reset_n = 1'h1;
   logic quad = 1'h0;
   logic addr4 = 1'h0;
   logic protection_scheme_select = 1'h0;
   logic busy = 1'h0;
   logic [3:0] idx = 4'h0;
   logic sclk, cs_n, write_enable_latch, lock_st, prot, dev_rst, abort;
   logic [3:0] host_io, dut_io, oe_n, link_io, pat;
   logic [127:0] rx;
   int fails = 0;
   int samples_checked = 0;
   int rst_cnt = 0;
   int abort_cnt = 0;
   int n, a, rd;
   // Clock, wire level, pulse counts
   always #2.5 ref_clk_i = ~ref_clk_i;
   assign link_io = (dut_io & ~oe_n) | (host_io & oe_n);
   always @(posedge ref_clk_i) begin
      if (dev_rst === 1'h1) rst_cnt++;
      if (abort === 1'h1) abort_cnt++;
   end
   always @(negedge ref_clk_i) protection_scheme_select <= 1'($urandom);
   sfuri_host host_u (.sclk_o(sclk), .cs_n_o(cs_n), .io_o(host_io),
      .io_i(link_io));
   sfuri_core #(.WRITE_ENABLE_OP(WRITE_ENABLE_CMD_OP), .UNIQUE_ID(ID_VAL),
      .PARAM_TABLE(TBL_VAL)) dut_u (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
      .io_i(link_io), .io_o(dut_io), .io_oe_n_o(oe_n), .reset_n_i(reset_n),
      .four_line_command_mode_i(quad), .addr4_mode_i(addr4),
      .protection_scheme_select_i(protection_scheme_select), .operation_in_progress_flag_i(busy),
      .lock_index_i(idx), .write_enable_latch_o(write_enable_latch),
      .lock_status_o(lock_st), .block_protected_o(prot),
      .device_reset_o(dev_rst), .operation_abort_o(abort));
   task automatic check(input logic [127:0] got, input logic [127:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic settle();
      repeat (6) @(negedge ref_clk_i);
   endtask
   task automatic cmd(input logic [7:0] op);
      host_u.frame({op, 56'h0}, 8, 1'h0, 0, rx);
      settle();
   endtask
   // Two zero nibbles, lets a mode change reach the link side
   task automatic pad();
      host_u.frame(64'h0, 8, 1'h1, 0, rx);
      settle();
   endtask
   task automatic lk(input logic e);
      idx = 4'($urandom);
      @(negedge ref_clk_i);
      check(lock_st, e);
      check(prot, protection_scheme_select & e);
   endtask
   function automatic logic [127:0] exp_tbl(input logic [3:0] s);
      return (TBL_VAL << (s * 8)) | (TBL_VAL >> (128 - s * 8));
   endfunction
   task automatic print_verdict();
      $display("checks=%0d fails=%0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Watchdog
   initial begin
      #300000;
      fails++;
      print_verdict();
   end
   initial begin
      void'($urandom(2));
      repeat (4) @(negedge ref_clk_i);
      rst_i = 1'h0;
      repeat (4) @(negedge ref_clk_i);
      for (int b = 0; b < 16; b++) begin
         idx = 4'(b);
         @(negedge ref_clk_i);
         check(lock_st, 1'h1);
      end
      cmd(sfuri_pkg::GLOBAL_UNLOCK_OP);
      lk(1'h1);
      cmd(WRITE_ENABLE_CMD_OP);
      host_u.frame({sfuri_pkg::GLOBAL_UNLOCK_OP, 56'h0}, 12, 1'h0, 0, rx);
      settle();
      lk(1'h1);
      check(write_enable_latch, 1'h1);
      quad = 1'h1;
      pad();
      host_u.frame({sfuri_pkg::GLOBAL_UNLOCK_OP, 56'h0}, 8, 1'h1, 0, rx);
      settle();
      lk(1'h0);
      check(write_enable_latch, 1'h0);
      quad = 1'h0;
      pad();
      $display("unlock test done");
      // arm then execute, busy work aborted
      busy = 1'h1;
      n = rst_cnt;
      a = abort_cnt;
      cmd(WRITE_ENABLE_CMD_OP);
      cmd(sfuri_pkg::RESET_ARM_OP);
      cmd(sfuri_pkg::RESET_EXEC_OP);
      busy = 1'h0;
      check(rst_cnt, n + 1);
      check(abort_cnt, a + 1);
      check(write_enable_latch, 1'h0);
      lk(1'h1);
      cmd(WRITE_ENABLE_CMD_OP);
      for (int k = 0; k < 2; k++) begin
         n = rst_cnt;
         cmd(sfuri_pkg::RESET_ARM_OP);
         cmd(k ? WRITE_ENABLE_CMD_OP : sfuri_pkg::NO_OPERATION_OP);
         check(write_enable_latch, 1'h1);
         cmd(sfuri_pkg::RESET_EXEC_OP);
         check(rst_cnt, n);
      end
      $display("soft reset test done");
      cmd(sfuri_pkg::GLOBAL_UNLOCK_OP);
      lk(1'h0);
      cmd(WRITE_ENABLE_CMD_OP);
      for (int k = 0; k < 2; k++) begin
         n = rst_cnt;
         a = abort_cnt;
         busy = 1'h1;
         // Pin reset lands in the data phase of a read
         fork
            host_u.frame({sfuri_pkg::READ_ID_OP, 56'h0}, 40, 1'h0, 8, rx);
            begin
               repeat (266) @(negedge ref_clk_i);
               check(oe_n, 4'hD);
               reset_n = 1'h0;
               @(negedge ref_clk_i);
               check(oe_n, 4'hF);
            end
         join
         repeat (k ? 210 : 100) @(negedge ref_clk_i);
         check(oe_n, 4'hF);
         reset_n = 1'h1;
         busy = 1'h0;
         repeat (200) @(negedge ref_clk_i);
         check(rst_cnt, n + k);
         check(abort_cnt, a + k);
         check(write_enable_latch, k == 0);
      end
      lk(1'h1);
      $display("pin reset test done");
      for (int k = 0; k < 2; k++) begin
         n = rst_cnt;
         // broken pattern, then the valid one
         pat = k ? 4'h5 : 4'h7;
         for (int j = 3; j >= 0; j--) host_u.pulse(pat[j]);
         settle();
         check(rst_cnt, n + k);
      end
      $display("signal reset test done");
      for (int m = 0; m < 3; m++) begin
         addr4 = (m == 1);
         quad = (m == 2);
         pad();
         // zero address of the selected width
         host_u.frame({sfuri_pkg::READ_ID_OP, 56'h0}, (m == 1) ? 48 : 40,
            quad, 128, rx);
         check(rx, ID_VAL);
      end
      addr4 = 1'h0;
      quad = 1'h0;
      pad();
      for (int t = 0; t < 3; t++) begin
         a = $urandom;
         rd = 1 + $urandom % 100;
         host_u.frame({sfuri_pkg::READ_TABLE_OP, 20'h0, 4'(a), 32'h0}, 40,
            1'h0, rd, rx);
         check(rx, exp_tbl(4'(a)) >> (128 - rd));
      end
      settle();
      check(oe_n, 4'hF);
      $display("read test done");
      print_verdict();
   end
endmodule
